// file: inc/ssc_pkg.sv
package ssc_pkg;

  localparam logic [3:0]  OFF_STATUS_LO = 4'h0;
  localparam logic [3:0]  OFF_STATUS_HI = 4'h4;
  localparam logic [3:0]  OFF_PRIV      = 4'h8;

  localparam int unsigned POS_INT_EN       = 1;
  localparam int unsigned POS_PRIOR_INT_EN = 5;
  localparam int unsigned POS_BIG_ENDIAN   = 6;
  localparam int unsigned POS_PRIOR_PRIV   = 8;
  localparam int unsigned POS_VECTOR_ST    = 9;
  localparam int unsigned POS_FLOAT_ST     = 13;
  localparam int unsigned POS_USER_EXT_ST  = 15;
  localparam int unsigned POS_ACCESS_PERM  = 18;
  localparam int unsigned POS_EXEC_READ    = 19;
  localparam int unsigned POS_PRIOR_LPAD   = 23;
  localparam int unsigned POS_DTRAP_GUARD  = 24;
  localparam int unsigned POS_DIRTY_32     = 31;
  localparam int unsigned POS_USER_WIDTH   = 32;
  localparam int unsigned POS_DIRTY_64     = 63;

  // writable fields only; everything else is reserved or derived
  localparam logic [63:0] STATUS_WR_MASK = 64'h0000_0003_018d_e762;
  localparam logic [63:0] STATUS_RST     = 64'h0000_0002_0000_0000;

  localparam logic [1:0]  UWF_32    = 2'h1;
  localparam logic [1:0]  UWF_64    = 2'h2;
  localparam logic [1:0]  CTX_DIRTY = 2'h3;

  typedef enum logic [1:0] {
    PRIV_USER = 2'b00,
    PRIV_SUP  = 2'b01,
    PRIV_MACH = 2'b11
  } ssc_priv_t;

  typedef enum logic [1:0] {
    ACC_LOAD  = 2'b00,
    ACC_STORE = 2'b01,
    ACC_FETCH = 2'b10
  } ssc_acc_t;

  typedef struct packed {
    logic     valid;
    ssc_acc_t kind;
    logic     pte_r;
    logic     pte_w;
    logic     pte_x;
    logic     pte_u;
  } ssc_chk_req_t;

endpackage

// file: rtl/ssc_status_csr.sv
`timescale 1ns/1ps
module ssc_status_csr
  import ssc_pkg::*;
#(
  parameter int unsigned SUP_WIDTH      = 64,
  parameter bit          UWF_FIXED      = 1'b0,
  parameter bit          SATP_MODE_ZERO = 1'b0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [3:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  input  wire logic         trap_enter_i,
  input  wire logic         trap_return_i,
  input  wire logic         priv_load_i,
  input  wire ssc_priv_t    priv_val_i,
  input  wire logic [15:0]  int_pend_i,
  input  wire logic [15:0]  int_src_en_i,
  input  wire logic         paging_i,
  input  wire ssc_chk_req_t chk_i,
  input  wire logic [63:0]  addr_i,
  input  wire logic [63:0]  operand_i,
  input  wire logic [63:0]  result_i,
  output ssc_priv_t         priv_o,
  output logic [63:0]       status_o,
  output logic              int_take_o,
  output logic              chk_done_o,
  output logic              chk_fault_o,
  output logic [63:0]       addr_o,
  output logic [63:0]       operand_o,
  output logic [63:0]       result_o
);

  localparam bit IS64 = (SUP_WIDTH == 64);

  logic [63:0] status_r;
  logic [63:0] status_nxt;
  ssc_priv_t   priv_r;
  ssc_priv_t   priv_nxt;

  ////////////////////////////////////////////////////////////////////////
  // software view of the stored word

  function automatic logic [63:0] view_of(input logic [63:0] s);
    logic [63:0] v;
    logic        dirty;
    v     = s;
    dirty = (s[POS_FLOAT_ST +: 2] == CTX_DIRTY) ||
            (s[POS_USER_EXT_ST +: 2] == CTX_DIRTY) ||
            (s[POS_VECTOR_ST +: 2] == CTX_DIRTY);
    if (SATP_MODE_ZERO) begin
      v[POS_ACCESS_PERM] = 1'b0;
    end
    if (IS64) begin
      v[POS_DIRTY_64] = dirty;
    end else begin
      v[POS_DIRTY_32] = dirty;
      v[63:32] = 32'h0;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the request, write at the ack edge

  logic        bus_req;
  logic        hit_lo;
  logic        hit_hi;
  logic        hit_priv;
  logic        wr_fire;
  logic        ack_nxt;
  logic [63:0] view_now;
  logic [31:0] rd_word;
  logic [31:0] dat_nxt;
  logic [31:0] lane_mask;

  assign bus_req  = wb_cyc_i & wb_stb_i;
  assign hit_lo   = (wb_adr_i == OFF_STATUS_LO);
  assign hit_hi   = (wb_adr_i == OFF_STATUS_HI) & IS64;
  assign hit_priv = (wb_adr_i == OFF_PRIV);
  assign wr_fire  = bus_req & wb_we_i & wb_ack_o & (hit_lo | hit_hi);
  assign ack_nxt  = bus_req & ~wb_ack_o;
  assign view_now = view_of(status_r);
  assign rd_word  = hit_lo   ? view_now[31:0] :
                    hit_hi   ? view_now[63:32] :
                    hit_priv ? {30'h0, priv_r} : 32'h0;
  assign dat_nxt  = ack_nxt ? rd_word : 32'h0;

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign lane_mask[8*b +: 8] = {8{wb_sel_i[b]}};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // software write merge

  logic [63:0] wdata64;
  logic [63:0] lane64;
  logic [63:0] fix_mask;
  logic [63:0] eff_mask;
  logic [63:0] sw_raw;
  logic [1:0]  uwf_new;
  logic        uwf_ok;
  logic        guard_set;
  logic        guard_new;
  logic        int_en_sw;
  logic [63:0] sw_val;

  assign wdata64   = hit_hi ? {wb_dat_i, 32'h0} : {32'h0, wb_dat_i};
  assign lane64    = hit_hi ? {lane_mask, 32'h0} : {32'h0, lane_mask};
  // width field and permit flag can be frozen by parameters
  assign fix_mask  = {30'h0, {2{IS64 & ~UWF_FIXED}}, 13'h1fff,
                      ~SATP_MODE_ZERO, 18'h3ffff};
  assign eff_mask  = lane64 & STATUS_WR_MASK & fix_mask;
  assign sw_raw    = (status_r & ~eff_mask) | (wdata64 & eff_mask);
  assign uwf_new   = sw_raw[POS_USER_WIDTH +: 2];
  assign uwf_ok    = (uwf_new == UWF_32) | (uwf_new == UWF_64);
  assign guard_set = eff_mask[POS_DTRAP_GUARD] & wdata64[POS_DTRAP_GUARD];
  assign guard_new = sw_raw[POS_DTRAP_GUARD];
  // a set guard bit forbids enabling interrupts in the same write and in later writes that leave it set
  assign int_en_sw = guard_set ? 1'b0 :
                     guard_new ? (status_r[POS_INT_EN] & sw_raw[POS_INT_EN]) :
                     sw_raw[POS_INT_EN];

  always_comb begin
    sw_val = sw_raw;
    sw_val[POS_INT_EN] = int_en_sw;
    if (!uwf_ok) begin
      sw_val[POS_USER_WIDTH +: 2] = status_r[POS_USER_WIDTH +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trap stack; hardware events override a write in the same cycle

  logic [63:0] base_val;
  assign base_val = wr_fire ? sw_val : status_r;

  always_comb begin
    status_nxt = base_val;
    priv_nxt   = priv_r;
    if (trap_enter_i) begin
      status_nxt[POS_PRIOR_PRIV]   = (priv_r != PRIV_USER);
      status_nxt[POS_PRIOR_INT_EN] = base_val[POS_INT_EN];
      status_nxt[POS_INT_EN]       = 1'b0;
      status_nxt[POS_DTRAP_GUARD]  = 1'b1;
      priv_nxt                     = PRIV_SUP;
    end else if (trap_return_i) begin
      priv_nxt = base_val[POS_PRIOR_PRIV] ? PRIV_SUP : PRIV_USER;
      status_nxt[POS_PRIOR_PRIV]   = 1'b0;
      status_nxt[POS_INT_EN]       = base_val[POS_PRIOR_INT_EN];
      status_nxt[POS_PRIOR_INT_EN] = 1'b1;
      status_nxt[POS_DTRAP_GUARD]  = 1'b0;
    end else if (priv_load_i) begin
      priv_nxt = priv_val_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt gate

  logic        src_any;
  logic        gate_sup;
  logic        gate_user;
  logic        take_nxt;

  assign src_any   = |(int_pend_i & int_src_en_i);
  assign gate_sup  = (priv_r == PRIV_SUP) & status_r[POS_INT_EN];
  assign gate_user = (priv_r == PRIV_USER);
  assign take_nxt  = src_any & (gate_sup | gate_user);

  ////////////////////////////////////////////////////////////////////////
  // page permission check for the current privilege

  logic        perm_mxr;
  logic        perm_sum;
  logic        xlate;
  logic        is_load;
  logic        is_store;
  logic        is_fetch;
  logic        load_bad;
  logic        store_bad;
  logic        fetch_bad;
  logic        sup_mode;
  logic        sum_bad;
  logic        sfetch_bad;
  logic        user_bad;
  logic        fault_nxt;

  assign perm_mxr   = view_now[POS_EXEC_READ];
  assign perm_sum   = view_now[POS_ACCESS_PERM];
  // machine mode bypasses translation, so the flags go idle there too
  assign xlate      = paging_i & (priv_r != PRIV_MACH);
  assign is_load    = (chk_i.kind == ACC_LOAD);
  assign is_store   = (chk_i.kind == ACC_STORE);
  assign is_fetch   = (chk_i.kind == ACC_FETCH);
  // readable or exec when flag set
  assign load_bad   = is_load & ~(chk_i.pte_r | (perm_mxr & chk_i.pte_x));
  assign store_bad  = is_store & ~chk_i.pte_w;
  assign fetch_bad  = is_fetch & ~chk_i.pte_x;
  assign sup_mode   = (priv_r == PRIV_SUP);
  assign sum_bad    = sup_mode & chk_i.pte_u & (is_load | is_store) & ~perm_sum;
  assign sfetch_bad = sup_mode & chk_i.pte_u & is_fetch;
  assign user_bad   = gate_user & ~chk_i.pte_u;
  assign fault_nxt  = chk_i.valid & xlate &
                      (load_bad | store_bad | fetch_bad | sum_bad | sfetch_bad | user_bad);

  ////////////////////////////////////////////////////////////////////////
  // narrow user width datapath

  logic        narrow;
  logic [63:0] addr_nxt;
  logic [63:0] opnd_nxt;
  logic [63:0] res_nxt;
  logic [63:0] rst_val;
  logic [63:0] view_nxt;

  assign narrow   = IS64 & gate_user & (status_r[POS_USER_WIDTH +: 2] == UWF_32);
  assign addr_nxt = narrow ? {32'h0, addr_i[31:0]} : addr_i;
  assign opnd_nxt = narrow ? {32'h0, operand_i[31:0]} : operand_i;
  assign res_nxt  = narrow ? {{32{result_i[31]}}, result_i[31:0]} : result_i;
  assign rst_val  = IS64 ? STATUS_RST : 64'h0;
  assign view_nxt = view_of(status_nxt);

  ////////////////////////////////////////////////////////////////////////
  // state and output registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= rst_val;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      priv_r <= PRIV_MACH;
    end else begin
      priv_r <= priv_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= ack_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else begin
      wb_dat_o <= dat_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      priv_o <= PRIV_MACH;
    end else begin
      priv_o <= priv_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= rst_val;
    end else begin
      status_o <= view_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_take_o <= 1'b0;
    end else begin
      int_take_o <= take_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chk_done_o <= 1'b0;
    end else begin
      chk_done_o <= chk_i.valid;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chk_fault_o <= 1'b0;
    end else begin
      chk_fault_o <= fault_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_o <= 64'h0;
    end else begin
      addr_o <= addr_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      operand_o <= 64'h0;
    end else begin
      operand_o <= opnd_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_o <= 64'h0;
    end else begin
      result_o <= res_nxt;
    end
  end

endmodule

// file: tb/ssc_status_csr_asserts.sv
`timescale 1ns/1ps
module ssc_status_csr_asserts
  import ssc_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_we_i,
  input wire logic         wb_ack_o,
  input wire logic         trap_enter_i,
  input wire logic         trap_return_i,
  input wire logic [15:0]  int_pend_i,
  input wire logic [15:0]  int_src_en_i,
  input wire logic         paging_i,
  input wire ssc_chk_req_t chk_i,
  input wire ssc_priv_t    priv_o,
  input wire logic [63:0]  status_o,
  input wire logic         int_take_o,
  input wire logic         chk_done_o,
  input wire logic         chk_fault_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a bus write in the same cycle would change the saved copies first
  wire quiet = !(wb_ack_o && wb_we_i);
  sequence s_enter; trap_enter_i && quiet; endsequence
  sequence s_ret; trap_return_i && !trap_enter_i && quiet; endsequence
  ////////////////////////////////////////////////////////////////////////
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  property p_spp; s_enter |=> status_o[8] == ($past(priv_o) != PRIV_USER) && priv_o == PRIV_SUP; endproperty
  property p_prior_int_enable; s_enter |=> status_o[5] == $past(status_o[1]) && !status_o[1]; endproperty
  property p_ret_priv; s_ret |=> priv_o == ($past(status_o[8]) ? PRIV_SUP : PRIV_USER) && !status_o[8]; endproperty
  property p_ret_ie; s_ret |=> status_o[1] == $past(status_o[5]) && status_o[5]; endproperty
  property p_sie_off; (priv_o == PRIV_SUP && !status_o[1])[*2] |-> !int_take_o; endproperty
  property p_user_on; (priv_o == PRIV_USER && |(int_pend_i & int_src_en_i))[*2] |-> int_take_o; endproperty
  property p_fetch;
    chk_i.valid && chk_i.kind == ACC_FETCH && chk_i.pte_u && paging_i && priv_o == PRIV_SUP
      |=> chk_done_o && chk_fault_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack not one cycle after request");
  a_spp: assert property (p_spp) else $error("origin flag wrong on trap entry");
  a_prior_int_enable: assert property (p_prior_int_enable) else $error("enable stack wrong on trap entry");
  a_ret_priv: assert property (p_ret_priv) else $error("privilege wrong on trap return");
  a_ret_ie: assert property (p_ret_ie) else $error("enable stack wrong on trap return");
  a_sie_off: assert property (p_sie_off) else $error("interrupt taken with enable clear");
  a_user_on: assert property (p_user_on) else $error("user mode interrupt not taken");
  a_fetch: assert property (p_fetch) else $error("supervisor fetch from user page allowed");
endmodule
bind ssc_status_csr ssc_status_csr_asserts i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .trap_enter_i(trap_enter_i),
  .trap_return_i(trap_return_i), .int_pend_i(int_pend_i), .int_src_en_i(int_src_en_i),
  .paging_i(paging_i), .chk_i(chk_i), .priv_o(priv_o), .status_o(status_o), .int_take_o(int_take_o),
  .chk_done_o(chk_done_o), .chk_fault_o(chk_fault_o));

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench
  import ssc_pkg::*;
();
  logic         clk_i, rst_i, cyc, we, te, tr, pl, pg, ack, take, done, fault;
  logic [3:0]   adr;
  logic [31:0]  dat, rdat, dat_o;
  logic [15:0]  pend;
  logic [63:0]  addr, res, addr_o, res_o, st, opnd_o;
  ssc_priv_t    pv, priv;
  ssc_chk_req_t chk;
  int           error_cnt = 0;
  int           checked = 0;

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // one line drives both cyc and stb: they always rise and fall together
  ssc_status_csr i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .trap_enter_i(te), .trap_return_i(tr), .priv_load_i(pl), .priv_val_i(pv), .int_pend_i(pend),
    .int_src_en_i(16'h0002), .paging_i(pg), .chk_i(chk), .addr_i(addr), .operand_i(addr),
    .result_i(res), .priv_o(priv), .status_o(st), .int_take_o(take), .chk_done_o(done),
    .chk_fault_o(fault), .addr_o(addr_o), .operand_o(opnd_o), .result_o(res_o));
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    cmp("wb_dat_o", 64'(e), 64'(rdat));
  endtask
  // k: 0 trap entry, 1 trap return, 2 privilege load
  task automatic strobe(input int k, input ssc_priv_t p);
    @(posedge clk_i);
    {te, tr, pl} <= {k == 0, k == 1, k == 2};
    pv <= p;
    @(posedge clk_i);
    {te, tr, pl} <= 3'h0;
  endtask
  task automatic chkop(input ssc_acc_t k, input logic [3:0] rwxu, input logic e);
    @(posedge clk_i);
    chk <= {1'b1, k, rwxu};
    @(posedge clk_i);
    chk.valid <= 1'b0;
    #1;
    cmp("chk_done_o", 64'h1, 64'(done));
    cmp("chk_fault_o", 64'(e), 64'(fault));
  endtask
  task automatic ichk(input logic [15:0] p, input logic e);
    @(posedge clk_i);
    pend <= p;
    repeat (3) @(posedge clk_i);
    #1;
    cmp("int_take_o", 64'(e), 64'(take));
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    error_cnt++;
    test_done;
  end

  initial begin
    rst_i = 1'b1;
    {cyc, we, te, tr, pl, pg, adr, dat, pend, chk} = '0;
    pv = PRIV_MACH;
    addr = 64'hffff_ffff_1234_5678;
    res = 64'h0000_0000_8000_0001;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(OFF_STATUS_LO, 32'h0);
    rchk(OFF_STATUS_HI, 32'h2);
    rchk(OFF_PRIV, 32'h3);
    rchk(4'hc, 32'h0);
    $display("test reset end");
    acc(1'b1, OFF_STATUS_LO, 32'hffff_ffff);
    rchk(OFF_STATUS_LO, 32'h018d_e760);
    rchk(OFF_STATUS_HI, 32'h8000_0002);
    acc(1'b1, OFF_STATUS_HI, 32'hffff_ffff);
    rchk(OFF_STATUS_HI, 32'h8000_0002);
    acc(1'b1, OFF_STATUS_LO, 32'h2);
    rchk(OFF_STATUS_LO, 32'h2);
    $display("test layout end");
    strobe(2, PRIV_SUP);
    strobe(0, PRIV_SUP);
    rchk(OFF_STATUS_LO, 32'h0100_0120);
    strobe(1, PRIV_SUP);
    #1;
    cmp("priv_o", 64'(PRIV_SUP), 64'(priv));
    rchk(OFF_STATUS_LO, 32'h22);
    rchk(OFF_PRIV, 32'h1);
    strobe(2, PRIV_USER);
    strobe(0, PRIV_USER);
    rchk(OFF_STATUS_LO, 32'h0100_0020);
    strobe(1, PRIV_USER);
    rchk(OFF_STATUS_LO, 32'h22);
    rchk(OFF_PRIV, 32'h0);
    $display("test trap end");
    acc(1'b1, OFF_STATUS_LO, 32'h0);
    ichk(16'h0002, 1'b1);
    ichk(16'h0001, 1'b0);
    strobe(2, PRIV_SUP);
    ichk(16'h0002, 1'b0);
    acc(1'b1, OFF_STATUS_LO, 32'h2);
    ichk(16'h0002, 1'b1);
    $display("test interrupt end");
    @(posedge clk_i);
    pg <= 1'b1;
    chkop(ACC_STORE, 4'b1101, 1'b1);
    acc(1'b1, OFF_STATUS_LO, 32'h0004_0002);
    chkop(ACC_STORE, 4'b1101, 1'b0);
    chkop(ACC_FETCH, 4'b0011, 1'b1);
    chkop(ACC_LOAD, 4'b0010, 1'b1);
    acc(1'b1, OFF_STATUS_LO, 32'h0008_0002);
    chkop(ACC_LOAD, 4'b0010, 1'b0);
    @(posedge clk_i);
    pg <= 1'b0;
    chkop(ACC_LOAD, 4'b0001, 1'b0);
    $display("test check end");
    acc(1'b1, OFF_STATUS_HI, 32'h1);
    rchk(OFF_STATUS_HI, 32'h1);
    strobe(2, PRIV_USER);
    repeat (2) @(posedge clk_i);
    #1;
    cmp("addr_o", 64'h0000_0000_1234_5678, addr_o);
    cmp("operand_o", 64'h0000_0000_1234_5678, opnd_o);
    cmp("result_o", 64'hffff_ffff_8000_0001, res_o);
    cmp("status_o", 64'h0000_0001_0008_0002, st);
    $display("test width end");
    test_done;
  end
endmodule
